// ===== shared/lcd_com_pkg.sv
// Package: register layout, reset values and carriers for the LCD common driver
`default_nettype none
package lcd_com_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] addr_lcd_common_driver_control = 4'h0;
  localparam logic [7:0] reset_lcd_common_driver_control = 8'h00;
  localparam logic [7:0] read_unmapped = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int pos_unused_bit7 = 7;
  localparam int pos_bias_hi = 6;
  localparam int pos_bias_lo = 5;
  localparam int pos_master_enable = 4;
  localparam int pos_pin_hi = 3;
  localparam int num_common_pins = 4;

  // ----------------------------------------------------------------
  // Bias resistor select codes
  // ----------------------------------------------------------------
  localparam logic [1:0] bias_100k = 2'h0;
  localparam logic [1:0] bias_50k = 2'h1;
  localparam logic [1:0] bias_25k = 2'h2;
  localparam logic [1:0] bias_12k5 = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] bias_current_select;
    logic lcd_master_enable;
    logic [3:0] common_pin_enable;
  } ctrl_fields_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic bias_path_on;
    logic [3:0] resistor_sel;
    logic [3:0] pad_common_sel;
    logic [3:0] mid_level_req;
  } pad_ctrl_s;

endpackage : lcd_com_pkg
`default_nettype wire

// ===== rtl/lcd_pad_decode.sv
// Pad select and bias decode for the common pins
`timescale 1ns/1ps
`default_nettype none
module lcd_pad_decode
  import lcd_com_pkg::*;
(
  // Register fields
  input wire ctrl_fields_s fields,
  // Decoded pad controls
  output var pad_ctrl_s pads
);

  // ----------------------------------------------------------------
  // One-hot resistor pair decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] resistor_onehot(input logic [1:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      bias_100k: r = 4'h1;
      bias_50k: r = 4'h2;
      bias_25k: r = 4'h4;
      bias_12k5: r = 4'h8;
    endcase
    return r;
  endfunction : resistor_onehot

  // ----------------------------------------------------------------
  // Per-pin routing; port direction control plays no part here
  // ----------------------------------------------------------------
  logic [3:0] common_on;

  genvar i;
  generate
    for (i = 0; i < num_common_pins; i++) begin : g_pin
      assign common_on[i] = fields.lcd_master_enable &
                            fields.common_pin_enable[i]; // see [RULE2]
    end
  endgenerate

  // One writer for the whole carrier keeps every field single-driven
  always_comb begin
    // Bias DC path only while the master enable is on
    pads.bias_path_on = fields.lcd_master_enable; // see [RULE5]
    pads.resistor_sel =
      resistor_onehot(fields.bias_current_select); // see [RULE4]
    pads.pad_common_sel = common_on; // see [RULE2]
    pads.mid_level_req = common_on; // see [RULE11]
  end

endmodule : lcd_pad_decode
`default_nettype wire

// ===== rtl/lcd_common_pin_driver_ctrl.sv
// Control register and pad drive for the software-driven LCD common lines
//
// Notes on behaviour
// [RULE1] Bit 4 is the master on/off of the common driver; 1 enables.
// [RULE2] Pin gives half-supply only when master and its pin enable are 1.
// [RULE3] Common routing needs no port direction setup as output.
// [RULE4] Bits 6:5 pick 100k, 50k, 25k or 12.5k ohm bias resistor pair.
// [RULE5] Master bit on powers the bias DC path; master bit off cuts it.
// [RULE6] Bits 3..0 pick commons 3..0; else port B5, B6, A3, A1 stay.
// [RULE7] Comparator variant: software clears pin select for commons 3, 2.
// [RULE8] Comparator variant: software sets output select for common 1.
// [RULE9] Bit 7 is unimplemented: writes ignored, reads zero.
// [RULE10] Software makes the common waveforms; no hardware frame sequencing.
// [RULE11] Each shared pin gets a pad select and a mid-level drive request.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_common_pin_driver_ctrl
  import lcd_com_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Normal port functions of the shared pins
  input wire logic port_b_bit5_out,
  input wire logic port_b_bit5_oe_n,
  input wire logic port_b_bit6_out,
  input wire logic port_b_bit6_oe_n,
  input wire logic port_a_bit3_out,
  input wire logic port_a_bit3_oe_n,
  input wire logic port_a_bit1_out,
  input wire logic port_a_bit1_oe_n,
  // Pad side
  output logic [3:0] pad_common_sel,
  output logic [3:0] pad_mid_level_req,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe_n,
  // Bias network
  output logic bias_path_on,
  output logic [3:0] bias_resistor_sel
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ctrl_fields_s ctrl;
    logic [7:0] rdata;
    pad_ctrl_s pads;
    logic [3:0] pad_out;
    logic [3:0] pad_oe_n;
  } state_s;

  state_s cur;
  state_s next_cur;
  reg_req_s req;
  pad_ctrl_s dec;
  logic [3:0] port_out;
  logic [3:0] port_oe_n;

  // Common index order: 3 = B5, 2 = B6, 1 = A3, 0 = A1
  assign port_out = {port_b_bit5_out, port_b_bit6_out,
                     port_a_bit3_out, port_a_bit1_out}; // see [RULE6]
  assign port_oe_n = {port_b_bit5_oe_n, port_b_bit6_oe_n,
                      port_a_bit3_oe_n, port_a_bit1_oe_n};
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic [7:0] pack_ctrl(input ctrl_fields_s f);
    return {1'b0, f}; // see [RULE9]
  endfunction : pack_ctrl

  // ----------------------------------------------------------------
  // Decode of the stored fields
  // ----------------------------------------------------------------
  lcd_pad_decode u_decode (
    .fields(cur.ctrl),
    .pads(dec)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.rdata = 8'h00;
    if (req.wr && req.addr == addr_lcd_common_driver_control) begin
      // Bit 7 is dropped; software alone shapes the waveforms
      next_cur.ctrl.bias_current_select =
        req.wdata[pos_bias_hi:pos_bias_lo]; // see [RULE4]
      next_cur.ctrl.lcd_master_enable =
        req.wdata[pos_master_enable]; // see [RULE1]
      next_cur.ctrl.common_pin_enable =
        req.wdata[pos_pin_hi:0]; // see [RULE6]
    end
    if (req.rd) begin
      if (req.addr == addr_lcd_common_driver_control) begin
        next_cur.rdata = pack_ctrl(cur.ctrl); // see [RULE9]
      end else begin
        next_cur.rdata = read_unmapped;
      end
    end
    // Pads follow the register one cycle later, so every output is a flop
    next_cur.pads = dec; // see [RULE11]
    for (int i = 0; i < num_common_pins; i++) begin
      if (dec.pad_common_sel[i]) begin
        // Driven regardless of port direction; the mid level comes from bias
        next_cur.pad_out[i] = 1'b0; // see [RULE3]
        next_cur.pad_oe_n[i] = 1'b0; // see [RULE3]
      end else begin
        next_cur.pad_out[i] = port_out[i]; // see [RULE2]
        next_cur.pad_oe_n[i] = port_oe_n[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur.ctrl <= ctrl_fields_s'(reset_lcd_common_driver_control[6:0]);
      cur.rdata <= 8'h00;
      cur.pads <= '0;
      cur.pad_out <= 4'h0;
      cur.pad_oe_n <= 4'hF;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign pad_common_sel = cur.pads.pad_common_sel;
  assign pad_mid_level_req = cur.pads.mid_level_req;
  assign bias_path_on = cur.pads.bias_path_on; // see [RULE5]
  assign bias_resistor_sel = cur.pads.resistor_sel;
  assign pad_out = cur.pad_out;
  assign pad_oe_n = cur.pad_oe_n;

endmodule : lcd_common_pin_driver_ctrl
`default_nettype wire

// ===== testbench/lcd_ctrl_props.sv
// Checker for the LCD common driver control ports
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_props (
  // Clock, reset and register port
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Port and pad side
  input wire logic port_b_bit5_out,
  input wire logic port_b_bit5_oe_n,
  input wire logic [3:0] pad_common_sel,
  input wire logic [3:0] pad_mid_level_req,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe_n,
  input wire logic bias_path_on,
  input wire logic [3:0] bias_resistor_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_wb; reg_wr && reg_addr == 4'h0 ##1 !reg_wr
    |=> bias_path_on == $past(reg_wdata[4], 2); endproperty
  a_wb: assert property (p_wb) else $error("bias path");
  property p_res; reg_wr && reg_addr == 4'h0 ##1 !reg_wr
    |=> bias_resistor_sel == 4'h1 << $past(reg_wdata[6:5], 2); endproperty
  a_res: assert property (p_res) else $error("resistor");
  property p_b7; reg_rdata[7] == 1'b0; endproperty
  a_b7: assert property (p_b7) else $error("bit 7 set");
  property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data");
  property p_mid; pad_mid_level_req == pad_common_sel; endproperty
  a_mid: assert property (p_mid) else $error("mid request");
  property p_on; pad_common_sel != 4'h0 |-> bias_path_on; endproperty
  a_on: assert property (p_on) else $error("no master");
  property p_drv; ((pad_out | pad_oe_n) & pad_common_sel) == 4'h0; endproperty
  a_drv: assert property (p_drv) else $error("pin not driven");
  property p_port; !$past(rst) && !pad_common_sel[3] |-> pad_out[3] ==
    $past(port_b_bit5_out) && pad_oe_n[3] == $past(port_b_bit5_oe_n);
  endproperty
  a_port: assert property (p_port) else $error("port lost");
  c_all: cover property (pad_common_sel == 4'hF);
  c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
  c_res: cover property (bias_resistor_sel == 4'h8);
endmodule : lcd_ctrl_props
bind lcd_common_pin_driver_ctrl lcd_ctrl_props i_props (.mclk(mclk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_b_bit5_out(port_b_bit5_out),
  .port_b_bit5_oe_n(port_b_bit5_oe_n), .pad_common_sel(pad_common_sel),
  .pad_mid_level_req(pad_mid_level_req), .pad_out(pad_out),
  .pad_oe_n(pad_oe_n), .bias_path_on(bias_path_on),
  .bias_resistor_sel(bias_resistor_sel));
`default_nettype wire

// ===== testbench/lcd_panel_model.sv
// Model of the LCD panel common lines
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
  // Pads
  input wire logic mclk,
  input wire logic [3:0] pad_mid_level_req,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe_n,
  // Seen at the panel
  output logic [3:0] mid_seen,
  output logic [3:0] line
);
  logic [3:0] level = 4'h0;
  // A released line has no pull, so it wanders rather than holding
  always @(posedge mclk) begin
    mid_seen <= pad_mid_level_req;
    level <= (pad_oe_n & ~level) | (~pad_oe_n & pad_out);
  end
  assign line = level;
endmodule : lcd_panel_model
`default_nettype wire

// ===== testbench/tb_top.sv
// Testbench for the LCD common driver control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected %0t: %h not %h", $time, a, b); end end
module tb_top;
  import lcd_com_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] pv = 4'h0;
  logic [3:0] pe = 4'hF;
  logic [7:0] reg_rdata, got;
  logic [3:0] sel, mid, pout, poe, rsel, pmid, pline;
  logic bias_on;
  int miscompares = 0;
  int checked = 0;
  initial forever #12.5 mclk = ~mclk;
  lcd_common_pin_driver_ctrl i_dut (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_b_bit5_out(pv[3]), .port_b_bit5_oe_n(pe[3]),
    .port_b_bit6_out(pv[2]), .port_b_bit6_oe_n(pe[2]),
    .port_a_bit3_out(pv[1]), .port_a_bit3_oe_n(pe[1]),
    .port_a_bit1_out(pv[0]), .port_a_bit1_oe_n(pe[0]),
    .pad_common_sel(sel), .pad_mid_level_req(mid),
    .pad_out(pout), .pad_oe_n(poe), .bias_path_on(bias_on),
    .bias_resistor_sel(rsel));
  lcd_panel_model i_panel (.mclk(mclk), .pad_mid_level_req(mid),
    .pad_out(pout), .pad_oe_n(poe), .mid_seen(pmid), .line(pline));
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // Read data stand for one cycle; taken at the edge that closes it
    @(posedge mclk);
    got = reg_rdata;
  endtask : rd
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2000) @(posedge mclk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK({rsel, poe, bias_on}, 9'h03E)
    `CHK({sel, mid, pout, reg_rdata}, 20'h00000)
    rd(4'h0);
    `CHK(got, 8'h00)
    // Comparator pin selects of that variant are software's job elsewhere
    wr(4'h0, 8'hFF);
    rd(4'h0);
    `CHK(got, 8'h7F)
    // Port direction is still input here, yet the commons must drive
    `CHK({sel, mid, poe, pout, bias_on, rsel}, 21'h1FE018)
    $display("test full enable done");
    pv <= 4'hA;
    pe <= 4'h0;
    // Software steps one common at a time, as a frame would
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {1'b0, 2'(c), 1'b1, 4'h1 << c});
      repeat (3) @(posedge mclk);
      `CHK({rsel, sel, pmid}, {3{4'h1 << c}})
      `CHK(pout, 4'hA & ~(4'h1 << c))
      `CHK(pline, 4'hA & ~(4'h1 << c))
    end
    $display("test code walk done");
    pv <= 4'h5;
    wr(4'h0, 8'h0F);
    repeat (3) @(posedge mclk);
    `CHK({sel, bias_on, pout, poe}, 13'h0050)
    pe <= 4'hF;
    wr(4'h3, 8'h1F);
    rd(4'h0);
    `CHK({got, poe, rsel}, 16'h0FF1)
    rd(4'h3);
    `CHK(got, 8'h00)
    $display("test master off done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
